// ===== fwsr_status.sv
// fwsr_status: write operation status reporter of a flash sequencer.
// assumes command decode and the embedded algorithm engine sit outside and
// hand in one-cycle pulses; all pins except the asynchronous reset i_arst_n are synchronous to i_clk.
// Overview of operation
// [R1] during program, polling bit reads the inverse of written bit 7
// [R2] on program completion polling shows true data, array returns after
// [R3] chip erase polling valid after the sixth write strobe
// [R4] sector erase polling valid after the last write strobe
// [R5] host polls erase status only inside selected unprotected sectors
// [R6] polling bit is 0 during erase, 1 after return to read
// [R7] host makes one extra confirming read near completion
// [R8] polling status only driven in program, erase, suspend or time-out
// [R9] protected program shows polling for about 1 us, data unchanged
// [R10] protected sector erase toggles about 150 us, nothing erased
// [R11] ready/busy pulled low while program, erase or reset runs
// [R12] while busy, program and erase commands ignored except suspend
// [R13] erase suspend releases ready/busy to floating
// [R14] ready/busy low right after the final write strobe
// [R15] hardware reset during an operation keeps busy for reset ready time
// [R16] idle reset ends within reset ready time; reads wait read delay
// [R17] toggle bit readable anywhere, valid after final strobe
// [R18] toggle bit one inverts on each read during operations
// [R19] read cycles delimited by oe/ce, or address valid and clock
// [R20] all-protected erase toggles about 100 us then returns to read
// [R21] toggle bit one stops toggling in erase suspend
// [R22] protected program toggles about 1 us then returns to read
// [R23] erase-suspend-program toggles until the program completes
// [R24] toggle bit two inverts on reads within erase-selected sectors
// [R25] timeout flag set when the pulse count limit is exceeded
`timescale 1ns/10ps
module fwsr_status
  import fwsr_pkg::*;
#(
  parameter int PROT_ERASE_CYCLES = PROT_ERASE_CYC,
  parameter int ALL_PROT_CYCLES = ALL_PROT_CYC,
  parameter int RESET_READY_CYCLES = RESET_READY_CYC
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_hw_reset_n,
  input wire fwsr_cmd_type i_cmd,
  input wire logic i_target_protected,
  input wire logic i_wdata7,
  input wire logic i_alg_done,
  input wire logic i_pulse_limit,
  input wire fwsr_strobe_type i_strobe,
  input wire logic i_addr_in_busy_bank,
  input wire logic i_addr_in_erase_sector,
  output logic o_cmd_accept,
  output logic o_status_drive,
  output fwsr_status_type o_status,
  output logic o_ready_busy_output_o,
  output logic o_ready_busy_output_oe_n,
  output logic o_read_ok
);

  fwsr_reg_type q;
  fwsr_reg_type d;
  logic rd_n;
  logic rd_evt;
  logic busy;
  logic toggling;

  // states in which the device pulls ready/busy low
  function automatic logic is_busy(input fwsr_state_type s, input logic rb);
    is_busy = (s == ST_PROG) || (s == ST_PPROT) || (s == ST_ERASE) ||
              (s == ST_EPROT) || (s == ST_SPROG) || ((s == ST_HWRST) && rb);
  endfunction

  // read cycle start: async uses the oe/ce combination, sync uses adv and clock
  assign rd_n = i_strobe.oe_n | i_strobe.ce_n;
  assign rd_evt = i_strobe.sync_mode ?
                  ((i_strobe.adv_n && !q.adv_n_prev) ||
                   (i_strobe.sclk && !q.sclk_prev && !i_strobe.adv_n)) :
                  (!rd_n && q.rd_n_prev); // R19

  assign busy = is_busy(q.state, q.rst_busy);
  // suspend leaves toggle bit one still, so it is not in this set
  assign toggling = (q.state == ST_PROG) || (q.state == ST_PPROT) ||
                    (q.state == ST_ERASE) || (q.state == ST_EPROT) ||
                    (q.state == ST_SPROG); // R17 R21 R23

  // next-state logic
  always_comb begin
    d = q;
    d.rd_n_prev = rd_n;
    d.adv_n_prev = i_strobe.adv_n;
    d.sclk_prev = i_strobe.sclk;
    o_cmd_accept = 1'b0;
    if (q.rh_cnt != CNT_ZERO) begin
      d.rh_cnt = q.rh_cnt - CNT_ONE;
    end
    case (q.state)
      ST_IDLE: begin
        // program and erase commands are only taken while ready
        if (i_cmd.prog) begin
          o_cmd_accept = 1'b1;
          d.d7 = i_wdata7;
          if (i_target_protected) begin
            d.state = ST_PPROT; // R9 R22
            d.cnt = CNT_W'(PROT_PROG_CYC - 1);
          end else begin
            d.state = ST_PROG; // R1 R14
          end
        end else if (i_cmd.chip_erase) begin
          o_cmd_accept = 1'b1;
          if (i_target_protected) begin
            d.state = ST_EPROT; // R20
            d.cnt = CNT_W'(ALL_PROT_CYCLES - 1);
          end else begin
            d.state = ST_ERASE; // R3 R14
          end
        end else if (i_cmd.sector_erase) begin
          o_cmd_accept = 1'b1;
          if (i_target_protected) begin
            d.state = ST_EPROT; // R10
            d.cnt = CNT_W'(PROT_ERASE_CYCLES - 1);
          end else begin
            d.state = ST_ERASE; // R4 R14
          end
        end
      end
      ST_PROG: begin
        // further program or erase commands fall through unheard
        if (i_alg_done) begin
          d.state = ST_IDLE; // R2
        end else if (i_cmd.sw_reset && q.fail) begin
          d.state = ST_IDLE;
        end
      end // R12
      ST_SPROG: begin
        if (i_alg_done) begin
          d.state = ST_SUSP; // R23
        end else if (i_cmd.sw_reset && q.fail) begin
          d.state = ST_IDLE;
        end
      end
      ST_ERASE: begin
        if (i_cmd.suspend) begin
          o_cmd_accept = 1'b1;
          d.state = ST_SUSP; // R12 R13
        end else if (i_alg_done) begin
          // erased cells read back as ones once the array is visible again
          d.state = ST_IDLE; // R6
          d.d7 = 1'b1; // R6
        end else if (i_cmd.sw_reset && q.fail) begin
          d.state = ST_IDLE;
        end
      end
      ST_SUSP: begin
        // protected program attempts during suspend are dropped
        if (i_cmd.resume) begin
          o_cmd_accept = 1'b1;
          d.state = ST_ERASE;
        end else if (i_cmd.prog && !i_target_protected) begin
          o_cmd_accept = 1'b1;
          d.d7 = i_wdata7;
          d.state = ST_SPROG;
        end
      end
      ST_PPROT, ST_EPROT: begin
        // no array change; status shown only for the fixed time
        if (q.cnt == CNT_ZERO) begin
          d.state = ST_IDLE; // R9 R10 R20 R22
        end else begin
          d.cnt = q.cnt - CNT_ONE;
        end
      end
      ST_HWRST: begin
        if (q.cnt != CNT_ZERO) begin
          d.cnt = q.cnt - CNT_ONE;
        end else if (i_hw_reset_n) begin
          d.state = ST_IDLE; // R15 R16
          d.rst_busy = 1'b0;
          d.rh_cnt = CNT_W'(READ_DELAY_CYC);
        end
      end
      default: begin
        d.state = ST_IDLE;
      end
    endcase
    // timeout flag: limit event wins over a same-cycle software reset
    if (i_cmd.sw_reset) begin
      d.fail = 1'b0;
    end
    if (i_pulse_limit && ((q.state == ST_PROG) || (q.state == ST_ERASE) ||
        (q.state == ST_SPROG))) begin
      d.fail = 1'b1; // R25
    end
    // toggle bits advance once per host read cycle
    if (rd_evt && toggling) begin
      d.tog1 = !q.tog1; // R18
    end
    if (rd_evt && i_addr_in_erase_sector &&
        ((q.state == ST_ERASE) || (q.state == ST_SUSP))) begin
      d.tog2 = !q.tog2; // R24
    end
    // hardware reset overrides the state, counters and timeout flag; busy held only if work was running
    if (!i_hw_reset_n && (q.state != ST_HWRST)) begin
      d.state = ST_HWRST; // R15 R16
      d.rst_busy = busy;
      d.cnt = CNT_W'(RESET_READY_CYCLES - 1);
      d.fail = 1'b0;
      d.rh_cnt = CNT_ZERO;
    end
  end

  // single state register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q.state <= ST_IDLE;
      q.cnt <= CNT_ZERO;
      q.rh_cnt <= CNT_ZERO;
      q.d7 <= 1'b0;
      q.tog1 <= 1'b0;
      q.tog2 <= 1'b0;
      q.fail <= 1'b0;
      q.rst_busy <= 1'b0;
      q.rd_n_prev <= 1'b1;
      q.adv_n_prev <= 1'b1;
      q.sclk_prev <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // status output: decoded from flops only, so it cannot glitch mid-read
  always_comb begin
    o_status.toggle_bit_one = q.tog1; // R17
    o_status.toggle_bit_two = q.tog2;
    o_status.timeout_flag_bit = q.fail;
    case (q.state)
      ST_PROG, ST_SPROG, ST_PPROT: o_status.data_polling_bit = !q.d7; // R1
      ST_ERASE, ST_EPROT: o_status.data_polling_bit = 1'b0; // R6
      ST_SUSP: o_status.data_polling_bit = 1'b1;
      default: o_status.data_polling_bit = q.d7; // R2
    endcase
  end

  // status replaces array data only while an operation owns the addressed area;
  // in suspend, only erase-selected sectors show status (R5 is the host's part)
  assign o_status_drive = ((q.state == ST_SUSP) && i_addr_in_erase_sector) ||
                          (toggling && i_addr_in_busy_bank); // R5 R8 R7
  assign o_ready_busy_output_o = 1'b0; // R11
  assign o_ready_busy_output_oe_n = !busy; // R11 R13
  assign o_read_ok = (q.state != ST_HWRST) && (q.rh_cnt == CNT_ZERO); // R16

  property p_prog_poll;
    @(posedge i_clk) disable iff (!i_arst_n)
    (q.state == ST_IDLE && i_cmd.prog && !i_target_protected && i_hw_reset_n)
      |=> (o_status.data_polling_bit == !$past(i_wdata7)) && !o_ready_busy_output_oe_n;
  endproperty
  a_prog_poll: assert property (p_prog_poll) else $error("program poll or busy wrong"); // R1

  property p_erase_poll;
    @(posedge i_clk) disable iff (!i_arst_n)
    (q.state == ST_ERASE) |-> !o_status.data_polling_bit && !o_ready_busy_output_oe_n;
  endproperty
  a_erase_poll: assert property (p_erase_poll) else $error("erase poll not zero"); // R6

  property p_susp_float;
    @(posedge i_clk) disable iff (!i_arst_n)
    (q.state == ST_ERASE && i_cmd.suspend && i_hw_reset_n) |=> o_ready_busy_output_oe_n;
  endproperty
  a_susp_float: assert property (p_susp_float) else $error("busy after suspend"); // R13

  property p_ignore_busy;
    @(posedge i_clk) disable iff (!i_arst_n)
    (q.state == ST_PROG && (i_cmd.sector_erase || i_cmd.chip_erase) && !i_alg_done &&
     !i_cmd.sw_reset && i_hw_reset_n) |=> (q.state == ST_PROG) && !$past(o_cmd_accept);
  endproperty
  a_ignore_busy: assert property (p_ignore_busy) else $error("command taken while busy"); // R12

  property p_toggle;
    @(posedge i_clk) disable iff (!i_arst_n)
    (rd_evt && q.state == ST_PROG && i_hw_reset_n && !i_alg_done)
      |=> o_status.toggle_bit_one != $past(o_status.toggle_bit_one);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle bit did not invert"); // R18

  property p_susp_still;
    @(posedge i_clk) disable iff (!i_arst_n)
    (q.state == ST_SUSP) |=> $stable(o_status.toggle_bit_one);
  endproperty
  a_susp_still: assert property (p_susp_still) else $error("toggle moved in suspend"); // R21

  property p_prot_prog;
    @(posedge i_clk) disable iff (!i_arst_n)
    (q.state == ST_PPROT && q.cnt == CNT_ZERO && i_hw_reset_n)
      |=> (q.state == ST_IDLE) && o_ready_busy_output_oe_n;
  endproperty
  a_prot_prog: assert property (p_prot_prog) else $error("protected program not ended"); // R9

  property p_prot_len;
    @(posedge i_clk) disable iff (!i_arst_n)
    (q.state == ST_IDLE && i_cmd.prog && i_target_protected && i_hw_reset_n)
      |=> (q.cnt == CNT_W'(PROT_PROG_CYC - 1)) && (q.state == ST_PPROT);
  endproperty
  a_prot_len: assert property (p_prot_len) else $error("protected window length wrong"); // R22

  property p_rst_busy;
    @(posedge i_clk) disable iff (!i_arst_n)
    (!i_hw_reset_n && busy && q.state != ST_HWRST)
      |=> !o_ready_busy_output_oe_n && !o_read_ok;
  endproperty
  a_rst_busy: assert property (p_rst_busy) else $error("busy dropped at reset"); // R15

  property p_fail;
    @(posedge i_clk) disable iff (!i_arst_n)
    (q.state == ST_PROG && i_pulse_limit && i_hw_reset_n) |=> o_status.timeout_flag_bit;
  endproperty
  a_fail: assert property (p_fail) else $error("timeout flag not set"); // R25

endmodule

// ===== fwsr_pkg.sv
// fwsr_pkg: constants and types for the flash write status reporter.
// assumes a 100 MHz core clock; all times are converted to cycles here.
package fwsr_pkg;

  // clock rate
  localparam int CLK_MHZ = 100;
  localparam int CLK_PERIOD_NS = 10;

  // protected program attempt shows status for about this long
  localparam int PROT_PROG_US = 1;
  localparam int PROT_PROG_CYC = PROT_PROG_US * CLK_MHZ;
  // protected sector erase attempt toggles for about this long
  localparam int PROT_ERASE_US = 150;
  localparam int PROT_ERASE_CYC = PROT_ERASE_US * CLK_MHZ;
  // chip erase with every selected sector protected
  localparam int ALL_PROT_US = 100;
  localparam int ALL_PROT_CYC = ALL_PROT_US * CLK_MHZ;
  // internal reset time, value not fixed elsewhere
  localparam int RESET_READY_US = 20;
  localparam int RESET_READY_CYC = RESET_READY_US * CLK_MHZ;
  // reset_high_read_delay, value not fixed elsewhere; rounded up
  localparam int READ_DELAY_NS = 200;
  localparam int READ_DELAY_CYC = (READ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  // sequencer states, one-hot
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_PROG  = 8'h02,
    ST_PPROT = 8'h04,
    ST_ERASE = 8'h08,
    ST_EPROT = 8'h10,
    ST_SUSP  = 8'h20,
    ST_SPROG = 8'h40,
    ST_HWRST = 8'h80
  } fwsr_state_type;

  // decoded command events, each a one-cycle pulse at the final write strobe
  typedef struct packed {
    logic prog;
    logic chip_erase;
    logic sector_erase;
    logic suspend;
    logic resume;
    logic sw_reset;
  } fwsr_cmd_type;

  // host read strobes as seen on the pins
  typedef struct packed {
    logic sync_mode;
    logic oe_n;
    logic ce_n;
    logic adv_n;
    logic sclk;
  } fwsr_strobe_type;

  // status bits placed on the data bus
  typedef struct packed {
    logic data_polling_bit;
    logic toggle_bit_one;
    logic timeout_flag_bit;
    logic toggle_bit_two;
  } fwsr_status_type;

  // complete block state
  typedef struct packed {
    fwsr_state_type state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] rh_cnt;
    logic d7;
    logic tog1;
    logic tog2;
    logic fail;
    logic rst_busy;
    logic rd_n_prev;
    logic adv_n_prev;
    logic sclk_prev;
  } fwsr_reg_type;

endpackage

// ===== fwsr_host_model.sv
// fwsr_host_model: host controller that runs status read cycles.
// assumes the bench raises i_go for one cycle and waits for o_done.
`timescale 1ns/10ps
module fwsr_host_model
  import fwsr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [1:0] i_kind,
  input wire logic i_slow,
  input wire fwsr_status_type i_status,
  output fwsr_strobe_type o_strobe,
  output logic o_done,
  output fwsr_status_type o_rd_status
);
  logic [2:0] hold_q = 3'h0;
  // strobes move just after the rising edge; a slow host holds them longer
  always @(posedge i_clk) begin
    if (i_go && hold_q == 3'h0) begin
      hold_q <= i_slow ? 3'h4 : 3'h2;
    end else if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
      if (hold_q == 3'h1) begin
        o_rd_status <= i_status;
      end
    end
  end
  assign o_done = hold_q == 3'h0;
  // kind 0: oe strobe, 1: ce strobe, 2: adv rise, 3: clock rise with adv held low
  always_comb begin
    o_strobe.sync_mode = i_kind[1];
    o_strobe.oe_n = !(i_kind == 2'h1 || (hold_q != 3'h0 && i_kind == 2'h0));
    o_strobe.ce_n = !(i_kind == 2'h0 || (hold_q != 3'h0 && i_kind == 2'h1));
    o_strobe.adv_n = !(i_kind == 2'h3 || (hold_q != 3'h0 && i_kind == 2'h2));
    o_strobe.sclk = hold_q != 3'h0 && i_kind == 2'h3;
  end
endmodule

// ===== fwsr_status_tb_top.sv
// fwsr_status_tb_top: self-checking bench for the status reporter.
// assumes the host model above; the ready/busy line has a pull-up.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module fwsr_status_tb_top;
  import fwsr_pkg::*;
  localparam int PE = 20;
  localparam int AP = 10;
  localparam int RR = 8;
  localparam fwsr_cmd_type C_PROG = 6'h20;
  localparam fwsr_cmd_type C_CHIP = 6'h10;
  localparam fwsr_cmd_type C_SEC = 6'h08;
  localparam fwsr_cmd_type C_SUSP = 6'h04;
  localparam fwsr_cmd_type C_RES = 6'h02;
  localparam fwsr_cmd_type C_SWR = 6'h01;
  logic clk = 0, arst_n = 0, hw_n = 1, prot = 0, wd7 = 0, done = 0, lim = 0;
  logic in_bank = 1, in_er = 0, go = 0, slow = 0;
  logic [1:0] kind = 2'h0;
  fwsr_cmd_type cmd = '0;
  fwsr_strobe_type strobe;
  fwsr_status_type st, rd_st;
  logic acc, drv, rb_o, rb_oe_n, rd_ok, rd_done, rb;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  // open drain with pull-up: floating reads high
  assign rb = rb_oe_n ? 1'b1 : rb_o;
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  fwsr_status #(.PROT_ERASE_CYCLES(PE), .ALL_PROT_CYCLES(AP), .RESET_READY_CYCLES(RR)) i_dut (
    .i_clk(clk), .i_arst_n(arst_n), .i_hw_reset_n(hw_n), .i_cmd(cmd),
    .i_target_protected(prot), .i_wdata7(wd7), .i_alg_done(done), .i_pulse_limit(lim),
    .i_strobe(strobe), .i_addr_in_busy_bank(in_bank), .i_addr_in_erase_sector(in_er),
    .o_cmd_accept(acc), .o_status_drive(drv), .o_status(st),
    .o_ready_busy_output_o(rb_o), .o_ready_busy_output_oe_n(rb_oe_n), .o_read_ok(rd_ok));
  fwsr_host_model i_host (.i_clk(clk), .i_go(go), .i_kind(kind), .i_slow(slow),
    .i_status(st), .o_strobe(strobe), .o_done(rd_done), .o_rd_status(rd_st));
  // accept is combinational, so it is looked at before the taking edge
  task automatic send(input fwsr_cmd_type c, input logic a);
    @(negedge clk) cmd = c;
    #1 `CHK("cmd_accept", a, acc)
    @(negedge clk) cmd = '0;
  endtask
  task automatic rd(output fwsr_status_type s);
    @(negedge clk) go = 1'b1;
    @(negedge clk) go = 1'b0;
    for (int i = 0; i < 20 && !rd_done; i++) @(negedge clk);
    s = rd_st;
  endtask
  task automatic fin();
    @(negedge clk) done = 1'b1;
    @(negedge clk) done = 1'b0;
    @(negedge clk);
  endtask
  task automatic wait_rb();
    for (int i = 0; i < 300 && rb !== 1'b1; i++) @(negedge clk);
  endtask
  task automatic t_prog();
    fwsr_status_type a, b;
    for (int v = 0; v < 4; v++) begin
      kind = v[1:0];
      wd7 = v[0];
      send(C_PROG, 1'b1);
      `CHK("busy", 1'b0, rb)
      rd(a);
      rd(b);
      `CHK("poll", ~v[0], b.data_polling_bit)
      `CHK("drive", 1'b1, drv)
      `CHK("tog1", ~a.toggle_bit_one, b.toggle_bit_one)
      send(C_CHIP, 1'b0);
      fin();
      rd(a);
      rd(b);
      `CHK("true", v[0], b.data_polling_bit)
      `CHK("tog1_stop", a.toggle_bit_one, b.toggle_bit_one)
      `CHK("ready", 1'b1, rb)
      `CHK("no_drive", 1'b0, drv)
    end
    kind = 2'h0;
  endtask
  task automatic t_erase();
    fwsr_status_type a, b;
    in_er = 1'b1;
    slow = 1'b1;
    send(C_SEC, 1'b1);
    rd(a);
    rd(b);
    `CHK("er_poll", 1'b0, b.data_polling_bit)
    `CHK("er_busy", 1'b0, rb)
    `CHK("tog2", ~a.toggle_bit_two, b.toggle_bit_two)
    `CHK("er_tog1", ~a.toggle_bit_one, b.toggle_bit_one)
    send(C_SUSP, 1'b1);
    `CHK("susp_rdy", 1'b1, rb)
    `CHK("susp_drive", 1'b1, drv)
    rd(a);
    rd(b);
    `CHK("susp_tog1", a.toggle_bit_one, b.toggle_bit_one)
    `CHK("susp_tog2", ~a.toggle_bit_two, b.toggle_bit_two)
    slow = 1'b0;
    wd7 = 1'b0;
    send(C_PROG, 1'b1);
    `CHK("sprog_busy", 1'b0, rb)
    rd(a);
    rd(b);
    `CHK("sprog_tog1", ~a.toggle_bit_one, b.toggle_bit_one)
    `CHK("sprog_poll", 1'b1, b.data_polling_bit)
    fin();
    `CHK("sprog_end", 1'b1, rb)
    send(C_RES, 1'b1);
    `CHK("res_busy", 1'b0, rb)
    fin();
    rd(a);
    `CHK("er_done", 1'b1, a.data_polling_bit)
    send(C_CHIP, 1'b1);
    rd(a);
    `CHK("chip_poll", 1'b0, a.data_polling_bit)
    fin();
    in_er = 1'b0;
  endtask
  // protected targets: fixed window of toggling, then back to read
  task automatic t_prot();
    fwsr_status_type a, b;
    int t0, len;
    for (int k = 0; k < 3; k++) begin
      len = k == 0 ? PROT_PROG_CYC : k == 1 ? PE : AP;
      prot = 1'b1;
      send(k == 0 ? C_PROG : k == 1 ? C_SEC : C_CHIP, 1'b1);
      t0 = cyc;
      prot = 1'b0;
      rd(a);
      rd(b);
      `CHK("prot_tog1", ~a.toggle_bit_one, b.toggle_bit_one)
      wait_rb();
      `CHK("prot_len", len, cyc - t0)
    end
  endtask
  task automatic t_tmo();
    fwsr_status_type a;
    send(C_PROG, 1'b1);
    @(negedge clk) lim = 1'b1;
    @(negedge clk) lim = 1'b0;
    rd(a);
    `CHK("tmo_set", 1'b1, a.timeout_flag_bit)
    send(C_SWR, 1'b0);
    rd(a);
    `CHK("tmo_clr", 1'b0, a.timeout_flag_bit)
    `CHK("tmo_rdy", 1'b1, rb)
  endtask
  task automatic t_hwr();
    int t0;
    send(C_PROG, 1'b1);
    @(negedge clk) hw_n = 1'b0;
    t0 = cyc;
    @(negedge clk) hw_n = 1'b1;
    wait_rb();
    `CHK("rst_busy", 1'b1, cyc - t0 >= RR && cyc - t0 <= RR + 2)
    t0 = cyc;
    for (int i = 0; i < 50 && rd_ok !== 1'b1; i++) @(negedge clk);
    `CHK("read_ok", 1'b1, cyc - t0 >= READ_DELAY_CYC && cyc - t0 <= READ_DELAY_CYC + 2)
    @(negedge clk) hw_n = 1'b0;
    @(negedge clk) hw_n = 1'b1;
    @(negedge clk);
    `CHK("idle_rst", 1'b1, rb)
    for (int i = 0; i < 60 && rd_ok !== 1'b1; i++) @(negedge clk);
    `CHK("idle_ok", 1'b1, rd_ok)
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // a hung handshake would otherwise stall the run forever
  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    t_prog();
    t_erase();
    t_prot();
    t_tmo();
    t_hwr();
    end_of_test();
  end
endmodule
